// *** shared/blink_pkg.sv ***
// types used by the blink sequencer; its bench does not import them
// assumes constants come from blink_regs.svh
package blink_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [9:0] permille_t;
   typedef logic [6:0] step_div_t;
   typedef enum logic [1:0] {
      chan_red,
      chan_green,
      chan_blue
   } channel_t;
endpackage

// *** shared/blink_regs.svh ***
// register offsets, field positions, reset values and timing for the blink sequencer
// assumes the includer uses these as plain constants; no logic lives here
`ifndef BLINK_REGS_SVH
`define BLINK_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_RED_BLINK_TIMES 8'h01
`define OFS_RED_BLINK_CYCLE 8'h02
`define OFS_GREEN_BLINK_TIMES 8'h03
`define OFS_GREEN_BLINK_CYCLE 8'h04
`define OFS_BLUE_BLINK_TIMES 8'h05
`define OFS_BLUE_BLINK_CYCLE 8'h06
`define OFS_GLOBAL_CONTROL 8'h0b
`define OFS_PATTERN_CONTROL 8'h11

// ----------------------------------------
// field positions
// ----------------------------------------
`define ON_DURATION_MSB 7
`define ON_DURATION_LSB 4
`define OFF_DURATION_MSB 3
`define OFF_DURATION_LSB 0
`define BLINK_ENABLE_BIT 3
`define PERIOD_SELECT_MSB 2
`define PERIOD_SELECT_LSB 0
`define BLINK_START_BIT 3
`define GROUP_SELECT_MSB 1
`define GROUP_SELECT_LSB 0
`define GROUP_SELECT_BLINK 2'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define REG_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_HZ 250000000
`define SWITCH_RATE_HZ 20000
`define SWITCH_PERIOD_CYCLES (`CLOCK_HZ / `SWITCH_RATE_HZ)
`define SWITCH_HIGH_CYCLES (`SWITCH_PERIOD_CYCLES / 2)
`define STEP_TIME_US 50
`define PERMILLE_FULL 10'd1000

`endif

// *** tb/blink_monitor.sv ***
// checker on the blink sequencer ports, bound to its top module
// assumes shadow copies of written bits match the design registers
`timescale 1ns/1ps
`default_nettype none
module blink_monitor #(
   parameter int SWITCH_PERIOD_CYCLES = 12500, // clocks per switching period
   parameter int SWITCH_HIGH_CYCLES = 6250     // drive clocks per period
) (
   input wire logic clock,               // core clock
   input wire logic rst,                 // sync reset
   input wire logic wr_commit,           // write pulse
   input wire logic [7:0] wr_addr,       // write offset
   input wire logic [7:0] wr_data,       // write byte
   input wire logic [7:0] rd_addr,       // read offset
   input wire logic [7:0] rd_data,       // read byte
   input wire logic red_output_switch,   // red gate
   input wire logic green_output_switch, // green gate
   input wire logic blue_output_switch,  // blue gate
   input wire logic [2:0] first_led_group, // led drive
   input wire logic sequencing_active    // run flag
);
   logic [2:0] en_q;
   logic [1:0] gsel_q;
   logic start_q;
   logic [7:0] rtimes_q;
   int hi_q;
   int lo_q;
   wire logic mapped = rd_addr inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, 8'h11};
   wire logic full_on = sequencing_active && en_q[0] && rtimes_q == 8'hf0 && red_output_switch;
   // shadows of the control bits, updated at the same edge as the design
   always_ff @(posedge clock) begin
      if (rst) begin
         en_q <= 3'h0;
         gsel_q <= 2'h0;
         start_q <= 1'b0;
         rtimes_q <= 8'h00;
      end else if (wr_commit) begin
         case (wr_addr)
            8'h01: rtimes_q <= wr_data;
            8'h02: en_q[0] <= wr_data[3];
            8'h04: en_q[1] <= wr_data[3];
            8'h06: en_q[2] <= wr_data[3];
            8'h0b: gsel_q <= wr_data[1:0];
            8'h11: start_q <= wr_data[3];
            default: ;
         endcase
      end
   end
   // run lengths: red drive high, and red dark while fully on
   always_ff @(posedge clock) begin
      hi_q <= (rst || !first_led_group[0]) ? 0 : hi_q + 1;
      lo_q <= (rst || !full_on || first_led_group[0]) ? 0 : lo_q + 1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_commit_seen;
      wr_commit && wr_addr == rd_addr && mapped ##1 !wr_commit && $stable(rd_addr);
   endsequence
   a_seq_flag_match: assert property (sequencing_active == (gsel_q == 2'h1 && start_q))
      else $error("run flag wrong");
   a_switch_gates_led: assert property ((first_led_group & ~$past({blue_output_switch, green_output_switch,
      red_output_switch})) == 3'h0)
      else $error("led on with switch off");
   a_idle_enabled_dark: assert property (!sequencing_active |=> (first_led_group & $past(en_q)) == 3'h0)
      else $error("enabled led lit while idle");
   a_select_gates_blink: assert property (gsel_q != 2'h1 |=> (first_led_group & $past(en_q)) == 3'h0)
      else $error("blink lit without select");
   a_pwm_high_bound: assert property (hi_q <= SWITCH_HIGH_CYCLES)
      else $error("drive high too long");
   a_full_on_gap: assert property (lo_q <= SWITCH_PERIOD_CYCLES + 1)
      else $error("full on channel stays dark");
   a_write_read_back: assert property (s_commit_seen |=> rd_data == $past(wr_data, 2))
      else $error("written byte not read back");
   a_unmapped_zero: assert property (!mapped |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind rgb_indicator_blink_sequencer blink_monitor #(.SWITCH_PERIOD_CYCLES(SWITCH_PERIOD_CYCLES),
   .SWITCH_HIGH_CYCLES(SWITCH_HIGH_CYCLES)) blink_monitor_inst (.clock(clock), .rst(rst), .wr_commit(wr_commit),
   .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
   .red_output_switch(red_output_switch), .green_output_switch(green_output_switch),
   .blue_output_switch(blue_output_switch), .first_led_group(first_led_group),
   .sequencing_active(sequencing_active));
`default_nettype wire

// *** tb/led_panel.sv ***
// indicator leds: count the clocks each one is driven
// assumes the drive is sampled on the core clock
`timescale 1ns/1ps
`default_nettype none
module led_panel (
   input wire logic clock,           // core clock
   input wire logic [2:0] leds,      // drive, bit0 red
   output logic [31:0] lit_red,      // red lit clocks
   output logic [31:0] lit_green,    // green lit clocks
   output logic [31:0] lit_blue      // blue lit clocks
);
   initial begin
      lit_red = 32'h0;
      lit_green = 32'h0;
      lit_blue = 32'h0;
   end
   // light output integrates drive; the model has no opinion on timing
   always @(posedge clock) begin
      lit_red <= lit_red + 32'(leds[0]);
      lit_green <= lit_green + 32'(leds[1]);
      lit_blue <= lit_blue + 32'(leds[2]);
   end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the blink sequencer
// assumes shortened switching period 8 and drive 4 clocks
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int SP = 8; // short switching period keeps the run small
   localparam int HI = 4;
   logic clock, rst, wr_commit, sw_r, sw_g, sw_b, seq_on;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   logic [2:0] leds;
   logic [31:0] lit_r, lit_g, lit_b;
   int num_errors = 0;
   int tests_run = 0;
   int pm[16] = '{0, 10, 25, 50, 75, 100, 150, 200, 300, 400, 500, 600, 700, 800, 900, 1000};
   logic [7:0] regs[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, 8'h11};
   rgb_indicator_blink_sequencer #(.SWITCH_PERIOD_CYCLES(SP), .SWITCH_HIGH_CYCLES(HI))
      rgb_indicator_blink_sequencer_inst (.clock(clock), .rst(rst), .wr_commit(wr_commit),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .red_output_switch(sw_r),
      .green_output_switch(sw_g), .blue_output_switch(sw_b), .first_led_group(leds),
      .sequencing_active(seq_on));
   led_panel led_panel_inst (.clock(clock), .leds(leds), .lit_red(lit_r), .lit_green(lit_g), .lit_blue(lit_b));
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %0h want %0h", $time, got, exp);
      end
   endtask
   // one-cycle commit; read offset follows so the checker sees read-back.
   // one settling edge follows, since the led drive lags the registers by a clock
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      wr_commit = 1'b1;
      wr_addr = a;
      wr_data = d;
      rd_addr = a;
      @(posedge clock);
      #1;
      wr_commit = 1'b0;
      @(posedge clock);
      #1;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      #1;
      rd_addr = a;
      repeat (2) @(posedge clock);
      #1;
      check({24'h0, rd_data}, {24'h0, exp});
   endtask
   // lit clocks over a window of n edges, per channel
   task measure(input int n, input int er, input int eg, input int eb);
      logic [31:0] r, g, b;
      r = lit_r;
      g = lit_g;
      b = lit_b;
      repeat (n) @(posedge clock);
      #1;
      check(lit_r - r, er);
      check(lit_g - g, eg);
      check(lit_b - b, eb);
   endtask
   task final_report;
      $display("mismatches %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // a hang beyond the expected ~44k clocks ends the run
   initial begin
      repeat (60000) @(posedge clock);
      num_errors++;
      final_report;
   end
   initial begin
      {rst, wr_commit, wr_addr, wr_data, rd_addr} = {1'b1, 25'h0};
      {sw_r, sw_g, sw_b} = 3'h7;
      repeat (20) @(posedge clock);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         wr(regs[i], {regs[i][3:0], 4'h6});
         rd_chk(regs[i], {regs[i][3:0], 4'h6});
      end
      wr(8'h07, 8'h5a);
      rd_chk(8'h07, 8'h00);
      $display("test registers done");
      measure(800, 400, 400, 400);
      sw_r = 1'b0;
      measure(800, 0, 400, 400);
      sw_r = 1'b1;
      $display("test steady drive done");
      // group select, times and enables first, start last
      wr(8'h0b, 8'h01);
      wr(8'h01, 8'h5a);
      wr(8'h03, 8'hba);
      wr(8'h05, 8'h21);
      wr(8'h02, 8'h08);
      wr(8'h04, 8'h08);
      wr(8'h06, 8'h08);
      wr(8'h11, 8'h08);
      measure(8000, 0, 0, pm[2] * 2 * HI);
      measure(24000, pm[5] * 4 * HI, (1000 - pm[10]) * 4 * HI, pm[2] * 2 * HI);
      wr(8'h01, 8'hf0);
      measure(800, 400, 0, pm[2] * 2 * HI);
      $display("test blink done");
      wr(8'h11, 8'h00);
      measure(800, 0, 0, 0);
      wr(8'h11, 8'h08);
      wr(8'h0b, 8'h00);
      measure(800, 0, 0, 0);
      wr(8'h11, 8'h00);
      wr(8'h01, 8'h10);
      wr(8'h02, 8'h09);
      wr(8'h0b, 8'h01);
      wr(8'h11, 8'h08);
      measure(8000, pm[1] * 5 * HI, 0, pm[2] * 2 * HI);
      $display("test stop and period done");
      final_report;
   end
endmodule
`default_nettype wire

// *** verilog/rgb_indicator_blink_sequencer.sv ***
// blink sequencer for the red, green and blue outputs of the first led group
// assumes the host serial slave hands over decoded writes as one-cycle commit pulses on clock
`include "blink_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rgb_indicator_blink_sequencer #(
   parameter int SWITCH_PERIOD_CYCLES = `SWITCH_PERIOD_CYCLES, // clocks per 20 khz switching period
   parameter int SWITCH_HIGH_CYCLES = `SWITCH_HIGH_CYCLES      // clocks of drive within one period
) (
   input wire logic clock,                      // 250 mhz core clock
   input wire logic rst,                        // synchronous reset, active high
   input wire logic wr_commit,                  // one-cycle pulse at final acknowledge of a write
   input wire logic [7:0] wr_addr,              // register offset of the write
   input wire logic [7:0] wr_data,              // data byte of the write
   input wire logic [7:0] rd_addr,              // register offset to read
   output logic [7:0] rd_data,                  // read data, registered
   input wire logic red_output_switch,          // red output gate
   input wire logic green_output_switch,        // green output gate
   input wire logic blue_output_switch,         // blue output gate
   output logic [2:0] first_led_group,          // led drive, bit0 red, bit1 green, bit2 blue
   output logic sequencing_active               // start bit set and blink function selected
);

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   // duration code to per-mille of the cycle period
   function automatic blink_pkg::permille_t code_to_permille(input logic [3:0] code);
      blink_pkg::permille_t pm;
      pm = 10'd0;
      case (code)
         4'h0: pm = 10'd0;
         4'h1: pm = 10'd10;
         4'h2: pm = 10'd25;
         4'h3: pm = 10'd50;
         4'h4: pm = 10'd75;
         4'h5: pm = 10'd100;
         4'h6: pm = 10'd150;
         4'h7: pm = 10'd200;
         4'h8: pm = 10'd300;
         4'h9: pm = 10'd400;
         4'ha: pm = 10'd500;
         4'hb: pm = 10'd600;
         4'hc: pm = 10'd700;
         4'hd: pm = 10'd800;
         4'he: pm = 10'd900;
         default: pm = `PERMILLE_FULL;
      endcase
      return pm;
   endfunction

   // period select to 50 us steps per per-mille (period_ms / 50)
   function automatic blink_pkg::step_div_t period_steps(input logic [2:0] sel);
      blink_pkg::step_div_t st;
      st = 7'd2;
      case (sel)
         3'h0: st = 7'd2;
         3'h1: st = 7'd5;
         3'h2: st = 7'd10;
         3'h3: st = 7'd20;
         3'h4: st = 7'd40;
         3'h5: st = 7'd60;
         3'h6: st = 7'd80;
         default: st = 7'd100;
      endcase
      return st;
   endfunction

   // ----------------------------------------
   // register file
   // ----------------------------------------
   blink_pkg::reg_byte_t times_q [3];
   blink_pkg::reg_byte_t cycle_q [3];
   blink_pkg::reg_byte_t global_q;
   blink_pkg::reg_byte_t pattern_q;
   logic [7:0] rd_data_q;

   wire logic [2:0] wr_times_sel;
   wire logic [2:0] wr_cycle_sel;
   wire logic wr_global;
   wire logic wr_pattern;
   wire logic start_rise;
   wire logic blink_selected;
   wire logic run_all;
   logic [7:0] rd_mux;

   // writes land only on the commit pulse from the serial slave
   assign wr_times_sel[0] = wr_commit && (wr_addr == `OFS_RED_BLINK_TIMES);
   assign wr_times_sel[1] = wr_commit && (wr_addr == `OFS_GREEN_BLINK_TIMES);
   assign wr_times_sel[2] = wr_commit && (wr_addr == `OFS_BLUE_BLINK_TIMES);
   assign wr_cycle_sel[0] = wr_commit && (wr_addr == `OFS_RED_BLINK_CYCLE);
   assign wr_cycle_sel[1] = wr_commit && (wr_addr == `OFS_GREEN_BLINK_CYCLE);
   assign wr_cycle_sel[2] = wr_commit && (wr_addr == `OFS_BLUE_BLINK_CYCLE);
   assign wr_global = wr_commit && (wr_addr == `OFS_GLOBAL_CONTROL);
   assign wr_pattern = wr_commit && (wr_addr == `OFS_PATTERN_CONTROL);

   // a start write while stopped restarts every channel in the same cycle
   assign start_rise = wr_pattern && wr_data[`BLINK_START_BIT] && !pattern_q[`BLINK_START_BIT];
   assign blink_selected = (global_q[`GROUP_SELECT_MSB:`GROUP_SELECT_LSB] == `GROUP_SELECT_BLINK);
   assign run_all = blink_selected && pattern_q[`BLINK_START_BIT];

   // register storage
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            times_q[i] <= `REG_RESET;
            cycle_q[i] <= `REG_RESET;
         end
         global_q <= `REG_RESET;
         pattern_q <= `REG_RESET;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wr_times_sel[i]) begin
               times_q[i] <= wr_data;
            end
            if (wr_cycle_sel[i]) begin
               cycle_q[i] <= wr_data;
            end
         end
         if (wr_global) begin
            global_q <= wr_data;
         end
         if (wr_pattern) begin
            pattern_q <= wr_data;
         end
      end
   end

   // read selection; unmapped offsets read as zero
   always_comb begin
      rd_mux = 8'h00;
      if (rd_addr == `OFS_RED_BLINK_TIMES) begin
         rd_mux = times_q[0];
      end else if (rd_addr == `OFS_RED_BLINK_CYCLE) begin
         rd_mux = cycle_q[0];
      end else if (rd_addr == `OFS_GREEN_BLINK_TIMES) begin
         rd_mux = times_q[1];
      end else if (rd_addr == `OFS_GREEN_BLINK_CYCLE) begin
         rd_mux = cycle_q[1];
      end else if (rd_addr == `OFS_BLUE_BLINK_TIMES) begin
         rd_mux = times_q[2];
      end else if (rd_addr == `OFS_BLUE_BLINK_CYCLE) begin
         rd_mux = cycle_q[2];
      end else if (rd_addr == `OFS_GLOBAL_CONTROL) begin
         rd_mux = global_q;
      end else if (rd_addr == `OFS_PATTERN_CONTROL) begin
         rd_mux = pattern_q;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_mux;
      end
   end

   assign rd_data = rd_data_q;

   // ----------------------------------------
   // shared time base
   // ----------------------------------------
   // one counter serves both the 20 khz switching and the 50 us blink step,
   // since both periods are the same length; restarting it on start keeps phases aligned
   logic [15:0] base_q;
   logic [15:0] base_d;
   wire logic base_wrap;
   wire logic switch_high;

   assign base_wrap = (base_q == 16'(SWITCH_PERIOD_CYCLES - 1));
   assign switch_high = (base_q < 16'(SWITCH_HIGH_CYCLES));

   always_comb begin
      base_d = base_q + 16'h0001;
      if (base_wrap || start_rise) begin
         base_d = 16'h0000;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         base_q <= 16'h0000;
      end else begin
         base_q <= base_d;
      end
   end

   // ----------------------------------------
   // per-channel sequencers
   // ----------------------------------------
   logic [6:0] div_q [3];
   blink_pkg::permille_t pm_q [3];
   wire logic [2:0] chan_run;
   wire logic [2:0] chan_lit;
   wire logic [2:0] chan_gate;
   wire logic [2:0] drive;
   logic [2:0] drive_q;

   assign chan_gate = {blue_output_switch, green_output_switch, red_output_switch};

   for (genvar c = 0; c < 3; c++) begin : g_chan
      wire blink_pkg::permille_t off_pm;
      wire blink_pkg::permille_t on_pm;
      wire logic [10:0] on_end;
      wire logic step_last;
      wire logic pm_last;
      wire logic enabled;

      assign enabled = cycle_q[c][`BLINK_ENABLE_BIT];
      assign off_pm = code_to_permille(times_q[c][`OFF_DURATION_MSB:`OFF_DURATION_LSB]);
      assign on_pm = code_to_permille(times_q[c][`ON_DURATION_MSB:`ON_DURATION_LSB]);
      assign on_end = {1'b0, off_pm} + {1'b0, on_pm};
      assign step_last = (div_q[c] == (period_steps(cycle_q[c][`PERIOD_SELECT_MSB:`PERIOD_SELECT_LSB]) - 7'd1));
      assign pm_last = (pm_q[c] == (`PERMILLE_FULL - 10'd1));
      assign chan_run[c] = run_all && enabled;
      // off first, then on; the phase counter never reaches 1000 so an overlong on time is cut
      // at the period end, and a short pair leaves the tail dark
      assign chan_lit[c] = (pm_q[c] >= off_pm) && ({1'b0, pm_q[c]} < on_end);

      // phase counter wraps every period and repeats while running
      always_ff @(posedge clock) begin
         if (rst || start_rise || !chan_run[c]) begin
            div_q[c] <= 7'd0;
            pm_q[c] <= 10'd0;
         end else if (base_wrap) begin
            if (step_last) begin
               div_q[c] <= 7'd0;
               pm_q[c] <= pm_last ? 10'd0 : pm_q[c] + 10'd1;
            end else begin
               div_q[c] <= div_q[c] + 7'd1;
            end
         end
      end

      // disabled channel is steady, running channel follows its cycle, stopped one is dark
      assign drive[c] = chan_gate[c] && switch_high &&
                        (enabled ? chan_run[c] && chan_lit[c] : 1'b1);
   end

   // output drive register
   always_ff @(posedge clock) begin
      if (rst) begin
         drive_q <= 3'h0;
      end else begin
         drive_q <= drive;
      end
   end

   assign first_led_group = drive_q;
   assign sequencing_active = run_all;

endmodule

`default_nettype wire
